// ===== src/bridge_prefetch_pkg.sv
// Purpose: shared constants and types for the upstream read prefetch block
// Assumes: 32-bit APB register bus, dword-wide completion data
// Notes: prefetch sizes are held in 32-byte units
package bridge_prefetch_pkg;

  // ----------------------------------------
  // link credits
  // ----------------------------------------
  localparam int unsigned CREDIT_BYTES = 16;
  localparam logic [7:0] CREDIT_PH = 8'h08;
  localparam logic [11:0] CREDIT_PD = 12'h020;
  localparam logic [7:0] CREDIT_NPH = 8'h04;
  localparam logic [11:0] CREDIT_NPD = 12'h001;
  localparam logic [7:0] CREDIT_CPLH = 8'h00;
  localparam logic [11:0] CREDIT_CPLD = 12'h000;

  typedef struct packed {
    logic [7:0] ph;
    logic [11:0] pd;
    logic [7:0] nph;
    logic [11:0] npd;
    logic [7:0] cplh;
    logic [11:0] cpld;
  } fc_credit_type;

  localparam fc_credit_type FC_INIT = '{CREDIT_PH, CREDIT_PD, CREDIT_NPH, CREDIT_NPD, CREDIT_CPLH, CREDIT_CPLD};

  // ----------------------------------------
  // commands and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_LINE = 2'b01,
    CMD_MULTIPLE = 2'b10
  } read_cmd_type;

  typedef struct packed {
    read_cmd_type cmd;
    logic [31:0] addr;
  } pci_read_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [8:0] dwords;
  } fetch_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_HOLD = 2'b10,
    ST_DROP = 2'b11
  } cache_state_type;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] OFF_PREFETCH = 12'h000;
  localparam logic [11:0] OFF_MISC = 12'h004;
  localparam logic [11:0] OFF_PERIOD = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;

  localparam int PF_PLAIN_EN = 0;
  localparam int PF_LINE_EN = 1;
  localparam int PF_MULT_EN = 2;
  localparam int PF_LINE_SLOW = 4;
  localparam int PF_LINE_FAST = 8;
  localparam int PF_MULT_SLOW = 12;
  localparam int PF_MULT_FAST = 16;
  localparam int MISC_SHORT_TERM_CACHE_ENABLE = 0;
  localparam int MISC_CLS = 8;

  localparam logic [31:0] PREFETCH_RESET = 32'h000c_8846;
  localparam logic [31:0] MISC_RESET = 32'h0000_0800;
  localparam logic [15:0] PERIOD_RESET = 16'h0100;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam logic [8:0] PLAIN_DW_NARROW = 9'h001;
  localparam logic [8:0] PLAIN_DW_WIDE = 9'h002;

endpackage

// ===== src/prefetch_store.sv
// Purpose: dword store for prefetched read data
// Assumes: one write and one read port on the same clock
// Notes: read data comes out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module prefetch_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 128
) (
  // clock
  input wire logic pclk,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("prefetch_store: bad size");
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ===== src/read_prefetch_bridge.sv
// Purpose: upstream read prefetch, short-term cache, credit advertisement
// Assumes: PCI and PCIe cores run on pclk; the link clock is sampled
// Notes: one cached read stream at a time
//
// Overview of operation
// - never retry or disconnect while delivering downstream read completions
// - each data credit stands for sixteen bytes of payload
// - completion credits infinite (zero); reads issued only with room for data
// - advertise eight posted header and thirty-two posted data credits
// - advertise four non-posted header and one non-posted data credit
// - line and multiple reads prefetch by default; plain reads do not
// - plain read fetches one dword narrow, two dwords wide by default
// - read-line prefetches 128 bytes narrow, 256 bytes wide by default
// - read-line prefetch disabled fetches exactly one cacheline
// - read-multiple prefetches 256 bytes narrow, 384 bytes wide by default
// - read-multiple prefetch disabled fetches exactly two cachelines
// - without short-term cache, drop leftover data when the master ends
// - with short-term cache, keep leftover data after the master ends
// - with short-term cache, keep fetching to the configured amount
// - a new read at the next undelivered dword of held data is served from the cache
// - after partial delivery, timer expiry drops the cached remainder
// - after partial delivery, an upstream posted write drops the remainder
`timescale 1ns/1ps
`default_nettype none
module read_prefetch_bridge #(
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  input wire logic link_clk,
  input wire logic link_up,
  output bridge_prefetch_pkg::fc_credit_type fc_adv,
  output logic fc_adv_valid,
  // pci side
  input wire logic pci_rd_req,
  input wire bridge_prefetch_pkg::pci_read_type pci_rd,
  input wire logic pci_bus64,
  input wire logic pci_data_req,
  input wire logic pci_txn_end,
  input wire logic pci_posted_wr,
  input wire logic pci_wr_attempt,
  input wire logic posted_space_low,
  input wire logic dn_cpl_active,
  output logic [31:0] pci_data,
  output logic pci_data_valid,
  output logic pci_hit,
  output logic pci_retry,
  // pcie side
  output logic fetch_valid,
  output bridge_prefetch_pkg::fetch_req_type fetch,
  input wire logic fetch_ready,
  input wire logic cpl_valid,
  input wire logic [31:0] cpl_data
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 120 || DEPTH > 256) begin
      $error("read_prefetch_bridge: DEPTH must hold the largest prefetch");
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] prefetch_ctrl;
  logic [31:0] misc_ctrl;
  logic [15:0] period;
  bridge_prefetch_pkg::cache_state_type state;
  logic cache_valid;
  logic txn_active;
  logic partial;
  logic [CW-1:0] total;
  logic [CW-1:0] fetched;
  logic [CW-1:0] rd_ptr;
  logic [31:0] base_addr;
  logic [15:0] timer;
  logic pend;

  wire logic apb_setup = psel & ~penable;
  wire logic apb_write = psel & penable & pready & pwrite;
  wire logic hit_pf = paddr == bridge_prefetch_pkg::OFF_PREFETCH;
  wire logic hit_misc = paddr == bridge_prefetch_pkg::OFF_MISC;
  wire logic hit_period = paddr == bridge_prefetch_pkg::OFF_PERIOD;
  wire logic hit_status = paddr == bridge_prefetch_pkg::OFF_STATUS;
  wire logic mapped = hit_pf | hit_misc | hit_period | hit_status;
  wire logic [31:0] status_word = {12'h000, state, cache_valid, partial, fetched, rd_ptr};
  wire logic [31:0] read_mux = hit_pf ? prefetch_ctrl :
    hit_misc ? misc_ctrl :
    hit_period ? {16'h0000, period} :
    hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      prdata <= read_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch_ctrl <= bridge_prefetch_pkg::PREFETCH_RESET;
      misc_ctrl <= bridge_prefetch_pkg::MISC_RESET;
      period <= bridge_prefetch_pkg::PERIOD_RESET;
    end else if (apb_write) begin
      if (hit_pf) begin
        prefetch_ctrl <= {12'h000, pwdata[19:4], 1'b0, pwdata[2:0]};
      end else if (hit_misc) begin
        misc_ctrl <= {16'h0000, pwdata[15:8], 7'h00, pwdata[0]};
      end else if (hit_period) begin
        period <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // prefetch size
  // ----------------------------------------
  wire logic plain_en = prefetch_ctrl[bridge_prefetch_pkg::PF_PLAIN_EN];
  wire logic line_en = prefetch_ctrl[bridge_prefetch_pkg::PF_LINE_EN];
  wire logic mult_en = prefetch_ctrl[bridge_prefetch_pkg::PF_MULT_EN];
  wire logic short_term_cache_enable = misc_ctrl[bridge_prefetch_pkg::MISC_SHORT_TERM_CACHE_ENABLE];
  wire logic [7:0] cls = misc_ctrl[bridge_prefetch_pkg::MISC_CLS +: 8];
  wire logic [3:0] line_sz = pci_bus64 ? prefetch_ctrl[bridge_prefetch_pkg::PF_LINE_FAST +: 4] :
    prefetch_ctrl[bridge_prefetch_pkg::PF_LINE_SLOW +: 4];
  wire logic [3:0] mult_sz = pci_bus64 ? prefetch_ctrl[bridge_prefetch_pkg::PF_MULT_FAST +: 4] :
    prefetch_ctrl[bridge_prefetch_pkg::PF_MULT_SLOW +: 4];
  wire logic [8:0] line_dw = {2'b00, line_sz, 3'b000};
  wire logic [8:0] mult_dw = {2'b00, mult_sz, 3'b000};
  wire logic [8:0] plain_dw = pci_bus64 ? bridge_prefetch_pkg::PLAIN_DW_WIDE :
    bridge_prefetch_pkg::PLAIN_DW_NARROW;
  // plain reads may hit side-effect space, so they stay minimal unless enabled
  wire logic [8:0] want_dw = (pci_rd.cmd == bridge_prefetch_pkg::CMD_LINE) ?
    (line_en ? line_dw : {1'b0, cls}) :
    (pci_rd.cmd == bridge_prefetch_pkg::CMD_MULTIPLE) ?
    (mult_en ? mult_dw : {cls, 1'b0}) :
    (plain_en ? line_dw : plain_dw);
  // never ask for more than the store can take, so completions always fit
  wire logic [8:0] fit_dw = (want_dw > 9'(DEPTH)) ? 9'(DEPTH) : want_dw;
  wire logic [8:0] next_total = (fit_dw == 9'h000) ? 9'h001 : fit_dw;

  // ----------------------------------------
  // cache control
  // ----------------------------------------
  wire logic busy = (state == bridge_prefetch_pkg::ST_FETCH) | (state == bridge_prefetch_pkg::ST_DROP);
  wire logic addr_match = pci_rd.addr == (base_addr + {{(30 - CW){1'b0}}, rd_ptr, 2'b00});
  wire logic req_hit = pci_rd_req & cache_valid & addr_match;
  wire logic req_start = pci_rd_req & ~req_hit & ~busy & ~fetch_valid;
  wire logic req_refused = pci_rd_req & ~req_hit & (busy | fetch_valid);
  wire logic deliver = pci_data_req & txn_active & cache_valid & (rd_ptr < fetched);
  wire logic expire = partial & ~txn_active & (timer == 16'h0000);
  wire logic drop_end = pci_txn_end & ~short_term_cache_enable;
  wire logic drop_cache = cache_valid & ((partial & pci_posted_wr) | expire | drop_end);
  wire logic cpl_take = cpl_valid & busy;
  wire logic fetch_done = cpl_take & (fetched + CW'(1) == total);
  wire logic store_wr = cpl_valid & (state == bridge_prefetch_pkg::ST_FETCH) & ~drop_cache;
  logic [31:0] store_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bridge_prefetch_pkg::ST_IDLE;
      cache_valid <= 1'b0;
      fetched <= '0;
      total <= '0;
      base_addr <= 32'h0000_0000;
    end else if (req_start) begin
      state <= bridge_prefetch_pkg::ST_FETCH;
      cache_valid <= 1'b1;
      fetched <= '0;
      total <= CW'(next_total);
      base_addr <= pci_rd.addr;
    end else begin
      // completions keep streaming after the master leaves while caching
      if (cpl_take) begin
        fetched <= fetched + CW'(1);
      end
      if (drop_cache) begin
        cache_valid <= 1'b0;
      end
      case (state)
        bridge_prefetch_pkg::ST_FETCH: begin
          if (drop_cache) begin
            state <= fetch_done ? bridge_prefetch_pkg::ST_IDLE : bridge_prefetch_pkg::ST_DROP;
          end else if (fetch_done) begin
            state <= bridge_prefetch_pkg::ST_HOLD;
          end
        end
        bridge_prefetch_pkg::ST_HOLD: begin
          if (drop_cache) begin
            state <= bridge_prefetch_pkg::ST_IDLE;
          end
        end
        bridge_prefetch_pkg::ST_DROP: begin
          // outstanding completions must still be absorbed before reuse
          if (fetch_done) begin
            state <= bridge_prefetch_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= bridge_prefetch_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txn_active <= 1'b0;
      rd_ptr <= '0;
      partial <= 1'b0;
      timer <= 16'h0000;
      pend <= 1'b0;
    end else begin
      pend <= deliver;
      if (req_start) begin
        rd_ptr <= '0;
        partial <= 1'b0;
      end else if (deliver) begin
        rd_ptr <= rd_ptr + CW'(1);
        partial <= 1'b1;
      end
      if (req_start | req_hit) begin
        txn_active <= 1'b1;
      end else if (pci_txn_end) begin
        txn_active <= 1'b0;
      end
      if (deliver | req_hit) begin
        timer <= period;
      end else if (timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
    end
  end

  prefetch_store #(
    .WIDTH(32),
    .DEPTH(DEPTH)
  ) u_store (
    .pclk(pclk),
    .wr_en(store_wr),
    .wr_addr(fetched[AW-1:0]),
    .wr_data(cpl_data),
    .rd_en(deliver),
    .rd_addr(rd_ptr[AW-1:0]),
    .rd_data(store_q)
  );

  // ----------------------------------------
  // pci and pcie outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pci_data <= 32'h0000_0000;
      pci_data_valid <= 1'b0;
      pci_hit <= 1'b0;
      pci_retry <= 1'b0;
      fetch_valid <= 1'b0;
      fetch <= '0;
    end else begin
      pci_data_valid <= pend;
      if (pend) begin
        pci_data <= store_q;
      end
      pci_hit <= req_hit;
      // only new requests are refused; completion delivery is never stalled
      pci_retry <= (req_refused | (pci_wr_attempt & posted_space_low)) & ~dn_cpl_active;
      if (req_start) begin
        fetch_valid <= 1'b1;
        fetch <= '{pci_rd.addr, next_total};
      end else if (fetch_ready) begin
        fetch_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // link credit advertisement
  // ----------------------------------------
  logic link_clk_s1, link_clk_s2, link_clk_s3;
  logic link_up_s1, link_up_s2;
  logic advertised;
  wire logic link_rise = link_clk_s2 & ~link_clk_s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_clk_s1 <= 1'b0;
      link_clk_s2 <= 1'b0;
      link_clk_s3 <= 1'b0;
      link_up_s1 <= 1'b0;
      link_up_s2 <= 1'b0;
      advertised <= 1'b0;
      fc_adv <= '0;
      fc_adv_valid <= 1'b0;
    end else begin
      link_clk_s1 <= link_clk;
      link_clk_s2 <= link_clk_s1;
      link_clk_s3 <= link_clk_s2;
      link_up_s1 <= link_up;
      link_up_s2 <= link_up_s1;
      fc_adv_valid <= 1'b0;
      if (!link_up_s2) begin
        advertised <= 1'b0;
      end else if (link_rise & ~advertised) begin
        advertised <= 1'b1;
        fc_adv_valid <= 1'b1;
        fc_adv <= bridge_prefetch_pkg::FC_INIT;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_retry_no_cpl: assert property (pci_retry |-> !$past(dn_cpl_active))
    else $error("retry during completion delivery");
  a_posted_credits: assert property (fc_adv_valid |-> fc_adv.ph == 8'h08 && fc_adv.pd == 12'h020)
    else $error("posted credits wrong");
  a_nonposted_credits: assert property (fc_adv_valid |-> fc_adv.nph == 8'h04 && fc_adv.npd == 12'h001)
    else $error("non-posted credits wrong");
  a_cpl_infinite: assert property (fc_adv_valid |-> fc_adv.cplh == 8'h00 && fc_adv.cpld == 12'h000)
    else $error("completion credits not infinite");
  a_line_one_cls: assert property (req_start && pci_rd.cmd == bridge_prefetch_pkg::CMD_LINE && !line_en
    && cls != 8'h00 |=> fetch.dwords == {1'b0, $past(cls)})
    else $error("read-line without prefetch not one cacheline");
  a_mult_default: assert property (req_start && pci_rd.cmd == bridge_prefetch_pkg::CMD_MULTIPLE && mult_en
    && mult_sz == 4'h8 |=> fetch.dwords == 9'h040)
    else $error("read-multiple default size wrong");
  a_drop_no_stc: assert property (pci_txn_end && !short_term_cache_enable && cache_valid && !req_start |=> !cache_valid)
    else $error("leftover data kept without caching");
  a_posted_drop: assert property (pci_posted_wr && partial && cache_valid && !req_start |=> !cache_valid)
    else $error("posted write did not drop cache");
  a_hit_data: assert property (deliver |-> ##2 pci_data_valid)
    else $error("cached data not delivered");
  a_timer_reload: assert property (deliver |=> timer == $past(period))
    else $error("discard timer not reloaded");
  a_fetch_room: assert property ($rose(fetch_valid) |-> fetched == '0 && fetch.dwords <= 9'(DEPTH))
    else $error("fetch issued without room");

  c_cache_hit: cover property (pci_hit);
  c_timer_drop: cover property (expire && cache_valid);
  c_advertise: cover property (fc_adv_valid);
  c_drop_state: cover property (state == bridge_prefetch_pkg::ST_DROP);

endmodule
`default_nettype wire

// ===== sim/pcie_completer_model.sv
// Purpose: completer on the far side, answering upstream read requests
// Assumes: one outstanding fetch at a time, as the bridge issues them
// Notes: each data word equals its own byte address, so order slips show
`timescale 1ns/1ps
`default_nettype none
module pcie_completer_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing
  input wire logic slow,
  // request and completion
  input wire logic fetch_valid,
  input wire bridge_prefetch_pkg::fetch_req_type fetch,
  output logic fetch_ready,
  output logic cpl_valid,
  output logic [31:0] cpl_data
);
  logic [31:0] addr;
  logic [8:0] left;
  logic [3:0] pace;
  // --------------------------------
  // request accept and completion stream
  // --------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_ready <= 1'b0;
      cpl_valid <= 1'b0;
      cpl_data <= 32'h0;
      addr <= 32'h0;
      left <= 9'h000;
      pace <= 4'h0;
    end else begin
      fetch_ready <= 1'b0;
      cpl_valid <= 1'b0;
      // idle data never repeats the last word
      cpl_data <= ~cpl_data;
      pace <= pace + 4'h1;
      if (left != 9'h000) begin
        if (!slow || pace[1:0] == 2'h3) begin
          cpl_valid <= 1'b1;
          // source words never change, so cached copies stay true
          cpl_data <= addr;
          addr <= addr + 32'h4;
          left <= left - 9'h001;
        end
      end else if (fetch_valid && !fetch_ready && (!slow || pace == 4'hf)) begin
        fetch_ready <= 1'b1;
        addr <= fetch.addr;
        left <= fetch.dwords;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/read_prefetch_bridge_tb.sv
// Purpose: self-checking bench for the read prefetch bridge
// Assumes: apb answers with one access cycle; completer model on the far side
// Notes: random addresses and line sizes from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module read_prefetch_bridge_tb;
  localparam logic [11:0] pf_off = bridge_prefetch_pkg::OFF_PREFETCH;
  localparam logic [11:0] misc_off = bridge_prefetch_pkg::OFF_MISC;
  localparam logic [11:0] stat_off = bridge_prefetch_pkg::OFF_STATUS;
  logic pclk = 1'b0, presetn = 1'b0, link_clk = 1'b0, link_up = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, fc_adv_valid;
  logic [31:0] pwdata = 32'h0, prdata, pci_data, cpl_data, rd_q, a;
  bridge_prefetch_pkg::fc_credit_type fc_adv;
  bridge_prefetch_pkg::pci_read_type pci_rd = '0;
  bridge_prefetch_pkg::fetch_req_type fetch;
  logic pci_rd_req = 1'b0, pci_bus64 = 1'b0, pci_data_req = 1'b0, pci_txn_end = 1'b0;
  logic pci_posted_wr = 1'b0, pci_wr_attempt = 1'b0, posted_space_low = 1'b0, dn_cpl_active = 1'b0;
  logic pci_data_valid, pci_hit, pci_retry, fetch_valid, fetch_ready, cpl_valid, rd_err;
  logic [7:0] cl;
  int err_total = 0, tests_run = 0;
  logic [8:0] tbl[6] = '{9'h001, 9'h002, 9'h020, 9'h040, 9'h040, 9'h060};
  logic [31:0] rst_exp[5] = '{32'h000c_8846, 32'h0000_0800, 32'h0000_0100, 32'h0, 32'h0};

  read_prefetch_bridge #(.DEPTH(128)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_up(link_up), .fc_adv(fc_adv), .fc_adv_valid(fc_adv_valid),
    .pci_rd_req(pci_rd_req), .pci_rd(pci_rd), .pci_bus64(pci_bus64), .pci_data_req(pci_data_req),
    .pci_txn_end(pci_txn_end), .pci_posted_wr(pci_posted_wr), .pci_wr_attempt(pci_wr_attempt),
    .posted_space_low(posted_space_low), .dn_cpl_active(dn_cpl_active), .pci_data(pci_data),
    .pci_data_valid(pci_data_valid), .pci_hit(pci_hit), .pci_retry(pci_retry), .fetch_valid(fetch_valid),
    .fetch(fetch), .fetch_ready(fetch_ready), .cpl_valid(cpl_valid), .cpl_data(cpl_data));
  pcie_completer_model partner_u (.pclk(pclk), .presetn(presetn), .slow(slow), .fetch_valid(fetch_valid),
    .fetch(fetch), .fetch_ready(fetch_ready), .cpl_valid(cpl_valid), .cpl_data(cpl_data));

  // --------------------------------
  // clocks and watchdog
  // --------------------------------
  always #5 pclk = ~pclk;
  always #40 link_clk = ~link_clk;
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic apb(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic rd_start(input logic [1:0] c, input logic [31:0] ad);
    pci_rd_req <= 1'b1;
    pci_rd <= '{cmd: bridge_prefetch_pkg::read_cmd_type'(c), addr: ad};
    @(posedge pclk);
    pci_rd_req <= 1'b0;
  endtask
  task automatic end_txn;
    pci_txn_end <= 1'b1;
    @(posedge pclk);
    pci_txn_end <= 1'b0;
  endtask
  task automatic wait_fetch(input logic [8:0] dw, input logic [31:0] ad);
    int k;
    k = 0;
    while (fetch_valid !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    chk({fetch_valid, fetch}, {1'b1, ad, dw}, "fetch request");
  endtask
  task automatic get_dw(input logic [31:0] exp);
    int k;
    k = 0;
    pci_data_req <= 1'b1;
    @(posedge pclk);
    pci_data_req <= 1'b0;
    while (pci_data_valid !== 1'b1 && k < 6) begin
      @(posedge pclk);
      k++;
    end
    chk({pci_data_valid, pci_data}, {1'b1, exp}, "data word");
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    void'($urandom(30));
    tick(20);
    presetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 5; i++) begin
      apb(12'(4 * i), 1'b0, 32'h0);
      chk({rd_err, rd_q}, {1'(i == 4), rst_exp[i]}, "reset value");
    end
    for (int i = 0; i < 2; i++) begin
      link_up <= 1'b1;
      for (int k = 0; k < 60 && fc_adv_valid !== 1'b1; k++) tick(1);
      chk({fc_adv_valid, fc_adv}, {1'b1, 8'h08, 12'h020, 8'h04, 12'h001, 8'h00, 12'h000}, "credits");
      link_up <= 1'b0;
      tick(10);
    end
    link_up <= 1'b1;
    $display("test credits done");
    // defaults per command and bus width, then drop on master end
    for (int i = 0; i < 6; i++) begin
      pci_bus64 <= i[0];
      a = $urandom() & 32'h7fff_ff00;
      rd_start(2'(i / 2), a);
      wait_fetch(tbl[i], a);
      tick(100);
      end_txn();
      tick(4);
      apb(stat_off, 1'b0, 32'h0);
      chk(rd_q[19:17], 3'h0, "leftover dropped");
    end
    $display("test default sizes done");
    // enables off: one and two cachelines of random size
    apb(pf_off, 1'b1, 32'h000c_8840);
    pci_bus64 <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cl = 8'($urandom_range(1, 16));
      apb(misc_off, 1'b1, {16'h0, cl, 8'h00});
      a = $urandom() & 32'h7fff_ff00;
      rd_start(2'(1 + i[0]), a);
      wait_fetch(9'(cl) << i[0], a);
      tick(40);
      end_txn();
    end
    // plain read with its prefetch enable set takes the line size
    apb(pf_off, 1'b1, 32'h000c_8841);
    a = $urandom() & 32'h7fff_ff00;
    rd_start(2'h0, a);
    wait_fetch(9'h020, a);
    tick(40);
    end_txn();
    $display("test cacheline sizes done");
    // short-term cache with a slow completer
    apb(pf_off, 1'b1, 32'h000c_8846);
    apb(misc_off, 1'b1, 32'h0000_0801);
    slow <= 1'b1;
    a = $urandom() & 32'h7fff_ff00;
    rd_start(2'h1, a);
    wait_fetch(9'h020, a);
    tick(30);
    get_dw(a);
    end_txn();
    tick(150);
    apb(stat_off, 1'b0, 32'h0);
    chk({rd_q[17], rd_q[15:8]}, {1'b1, 8'h20}, "cache kept and filled");
    rd_start(2'h1, a + 32'h4);
    tick(1);
    chk(pci_hit, 1'b1, "cache hit");
    tick(2);
    get_dw(a + 32'h4);
    end_txn();
    tick(200);
    apb(stat_off, 1'b0, 32'h0);
    chk(rd_q[17], 1'b1, "timer reloaded on delivery");
    tick(80);
    apb(stat_off, 1'b0, 32'h0);
    chk(rd_q[17], 1'b0, "timer expiry drop");
    // posted write drops the remainder
    slow <= 1'b0;
    a = $urandom() & 32'h7fff_ff00;
    rd_start(2'h1, a);
    wait_fetch(9'h020, a);
    tick(40);
    get_dw(a);
    pci_posted_wr <= 1'b1;
    tick(1);
    pci_posted_wr <= 1'b0;
    tick(3);
    apb(stat_off, 1'b0, 32'h0);
    chk(rd_q[17], 1'b0, "posted write drop");
    $display("test short-term cache done");
    // retry policy during a slow fetch
    slow <= 1'b1;
    a = $urandom() & 32'h7fff_ff00;
    rd_start(2'h1, a);
    wait_fetch(9'h020, a);
    dn_cpl_active <= 1'b1;
    rd_start(2'h2, a ^ 32'h8000_0000);
    tick(1);
    chk(pci_retry, 1'b0, "no retry while completing");
    tick(2);
    dn_cpl_active <= 1'b0;
    rd_start(2'h2, a ^ 32'h8000_0000);
    tick(1);
    chk(pci_retry, 1'b1, "retry on busy miss");
    tick(2);
    pci_wr_attempt <= 1'b1;
    posted_space_low <= 1'b1;
    tick(1);
    pci_wr_attempt <= 1'b0;
    tick(1);
    chk(pci_retry, 1'b1, "retry on short buffer");
    tick(2);
    posted_space_low <= 1'b0;
    // reset in mid-run empties the cache
    tick(150);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    tick(1);
    apb(stat_off, 1'b0, 32'h0);
    chk(rd_q[17], 1'b0, "cache empty after reset");
    $display("test retry and reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
